// ==== rtl/rtdr_consts.vh ====
`ifndef RTDR_CONSTS_VH
`define RTDR_CONSTS_VH

// ----------------------------------------------------------------------
// Global register byte offsets.
// ----------------------------------------------------------------------
`define RTDR_ADR_IRQ_STAT     12'h000
`define RTDR_ADR_IRQ_MASK     12'h004
`define RTDR_ADR_RANGE_LO     12'h008
`define RTDR_ADR_RANGE_HI     12'h00c
`define RTDR_ADR_LIMIT_ONE    12'h010
`define RTDR_ADR_LIMIT_TWO    12'h014
`define RTDR_ADR_LIMIT_EN     12'h018
`define RTDR_ADR_SFS_MAXSUB   12'h01c
`define RTDR_ADR_SFM_MAXSUB   12'h020

// ----------------------------------------------------------------------
// Per-channel window: base 0x200, 0x40 bytes per channel.
// ----------------------------------------------------------------------
`define RTDR_CH_BASE_SEL      3'h1
`define RTDR_W_INPUT_MAXSUB   4'h0
`define RTDR_W_STATUS         4'h1
`define RTDR_W_VALUE          4'h2
`define RTDR_W_INT_MAXSUB     4'h3
`define RTDR_W_SENS_RAW       4'h4
`define RTDR_W_SENS_RES       4'h5
`define RTDR_W_LINE_RAW       4'h6
`define RTDR_W_LINE_RES       4'h7
`define RTDR_W_CAL_MAXSUB     4'h8
`define RTDR_W_CAL_FIRST      4'h9
`define RTDR_CAL_ENTRIES      6

// ----------------------------------------------------------------------
// Channel status word field positions.
// ----------------------------------------------------------------------
`define RTDR_ST_UNDER         0
`define RTDR_ST_OVER          1
`define RTDR_ST_LIM1_LO       2
`define RTDR_ST_LIM2_LO       4
`define RTDR_ST_ERR           6
`define RTDR_ST_INVALID       7
`define RTDR_ST_TOGGLE        8
`define RTDR_ST_W             9

// ----------------------------------------------------------------------
// Limit result encodings.
// ----------------------------------------------------------------------
`define RTDR_LIM_OFF          2'h0
`define RTDR_LIM_ABOVE        2'h1
`define RTDR_LIM_BELOW        2'h2
`define RTDR_LIM_EQUAL        2'h3

// ----------------------------------------------------------------------
// Fixed readings and reset values.
// ----------------------------------------------------------------------
`define RTDR_INPUT_MAXSUB     8'h11
`define RTDR_INT_MAXSUB       8'h04
`define RTDR_CAL_MAXSUB       8'h06
`define RTDR_SFS_MAXSUB       8'h06
`define RTDR_SFM_MAXSUB       8'h03
`define RTDR_CAL_OFFS_RST     16'h0000
`define RTDR_CAL_GAIN_RST     16'h9e50
`define RTDR_RANGE_LO_RST     16'hf830
`define RTDR_RANGE_HI_RST     16'h2134
`define RTDR_VALUE_RST        16'h0000

`endif

// ==== rtl/rtdr_readout.v ====
// Overview of operation
// R1: Underrange flag set while sample lies below range low bound, else clear.
// R2: Overrange flag above high bound; with error it marks an open sensor.
// R3: Limit fields: 0 off, 1 above, 2 below, 3 equal to the limit.
// R4: Error flag set whenever the presented channel data is not valid.
// R5: Validity bit reads 0 for valid data and 1 for invalid data.
// R6: Toggle bit inverts at every refresh of a channel's data.
// R7: Measured value is signed 16 bits, zero after reset.
// R8: Sensor resistance is unsigned 16 bits at 1/32 ohm per LSB.
// R9: Supply-line resistance, where built, unsigned 16 bits at 1/32 ohm.
// R10: Raw converter results for sensor and line are signed 32-bit read-only.
// R11: Four-channel: writable offset/gain pairs, offsets 0, gains 0x9e50.
// R12: Eight-channel: per-channel offset/gain plus a high-resistance pair.
// R13: Input object max subindex reads seventeen.
// R14: Flags, limits, error and value update together with the toggle.
`timescale 1ns/100ps
`include "rtdr_consts.vh"

module rtdr_readout #(
  // Number of channels; the address map has room for eight at most.
  parameter NCH      = 4,
  // Zero builds a part without the supply-line measurement, so the line
  // fields read as zero whatever the converter presents.
  parameter HAS_LINE = 1,
  // Marks the eight-channel calibration layout; the storage is the same,
  // only the meaning of entries two to five differs, so no logic uses it.
  parameter CAL8     = 0
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              rst_i,
  // Wishbone classic slave.
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [11:0]       wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output wire [31:0]       wb_dat_o,
  output wire              wb_ack_o,
  // Converter side, one slice per channel.
  // A slice is taken on its channel's strobe only; between strobes the
  // converter may change it freely.
  input  wire [NCH-1:0]    smp_stb_i,
  input  wire [NCH-1:0]    smp_ok_i,
  input  wire [NCH*16-1:0] smp_value_i,
  input  wire [NCH*32-1:0] smp_sens_raw_i,
  input  wire [NCH*16-1:0] smp_sens_res_i,
  input  wire [NCH*32-1:0] smp_line_raw_i,
  input  wire [NCH*16-1:0] smp_line_res_i,
  // Calibration words handed to the converter.
  // Six 16-bit words per channel, entry zero in the low bits.
  output wire [NCH*96-1:0] cal_o,
  // Interrupt.
  output wire              irq_o
);

  // --------------------------------------------------------------------
  // Bus slave state.
  // --------------------------------------------------------------------
  // Configuration words are sixteen bits wide, the limit enable two; upper bus bits read zero.
  reg  [31:0]       dat_ff;
  reg               ack_ff;
  reg  [15:0]       irq_stat_ff;
  reg  [15:0]       irq_mask_ff;
  reg  [15:0]       range_lo_ff;
  reg  [15:0]       range_hi_ff;
  reg  [15:0]       lim_one_ff;
  reg  [15:0]       lim_two_ff;
  reg  [1:0]        lim_en_ff;
  reg  [31:0]       nxt_dat;
  reg  [15:0]       nxt_irq_stat;

  // Decoded pieces of the current request.
  wire              req;
  wire              wr_now;
  wire              ch_hit;
  wire [2:0]        ch_sel;
  wire [3:0]        ch_word;
  wire [15:0]       wmask16;

  // Per-channel fields gathered flat, so the read mux can index them.
  wire [NCH*`RTDR_ST_W-1:0] st_flat;
  wire [NCH*16-1:0]         val_flat;
  wire [NCH*32-1:0]         sraw_flat;
  wire [NCH*16-1:0]         sres_flat;
  wire [NCH*32-1:0]         lraw_flat;
  wire [NCH*16-1:0]         lres_flat;
  wire [NCH-1:0]            ev_fresh;
  wire [NCH-1:0]            ev_err;

  // Byte lanes two and three carry nothing writable, so only the two low
  // select bits enter the write mask.
  // A request is answered one cycle after it appears; the write lands on
  // the same edge at which the master sees ack, so it happens only once.
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_now  = req & wb_we_i & ack_ff;
  assign ch_hit  = (wb_adr_i[11:9] == `RTDR_CH_BASE_SEL) &&
                   ({1'b0, wb_adr_i[8:6]} < NCH);
  assign ch_sel  = wb_adr_i[8:6];
  assign ch_word = wb_adr_i[5:2];
  assign wmask16 = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Both bus outputs come straight from flip-flops, so a master with a
  // long path on its own side still sees clean values.
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // --------------------------------------------------------------------
  // Per-channel sample capture.
  // --------------------------------------------------------------------
  // One slice of flags, results and calibration words per channel; the
  // slices share only the range and limit settings.
  genvar g;
  genvar e;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg               under_ff;
      reg               over_ff;
      reg  [1:0]        lim1_ff;
      reg  [1:0]        lim2_ff;
      reg               err_ff;
      reg               tog_ff;
      reg  [15:0]       val_ff;
      reg  [31:0]       sraw_ff;
      reg  [15:0]       sres_ff;
      reg  [31:0]       lraw_ff;
      reg  [15:0]       lres_ff;
      reg  [15:0]       cal_ff [0:`RTDR_CAL_ENTRIES-1];
      wire signed [15:0] sv;
      wire              nxt_under;
      wire              nxt_over;
      wire              nxt_err;
      wire [1:0]        nxt_lim1;
      wire [1:0]        nxt_lim2;
      integer           k;

      // The value is two's complement, so every bound is read as signed;
      // an unsigned compare would put negative readings above the range.
      assign sv        = smp_value_i[g*16 +: 16];
      assign nxt_under = sv < $signed(range_lo_ff);             // see R1
      assign nxt_over  = sv > $signed(range_hi_ff);             // see R2
      // Out-of-range data is not usable, so it also counts as invalid;
      // an open sensor therefore shows overrange and error together.
      assign nxt_err   = ~smp_ok_i[g] | nxt_under | nxt_over;   // see R2 R4
      // A disabled limit reads zero whatever the value, so software can
      // tell an unwatched limit apart from any of the three results.
      assign nxt_lim1  = ~lim_en_ff[0] ? `RTDR_LIM_OFF :         // see R3
                         (sv > $signed(lim_one_ff)) ? `RTDR_LIM_ABOVE :
                         (sv < $signed(lim_one_ff)) ? `RTDR_LIM_BELOW :
                         `RTDR_LIM_EQUAL;
      assign nxt_lim2  = ~lim_en_ff[1] ? `RTDR_LIM_OFF :         // see R3
                         (sv > $signed(lim_two_ff)) ? `RTDR_LIM_ABOVE :
                         (sv < $signed(lim_two_ff)) ? `RTDR_LIM_BELOW :
                         `RTDR_LIM_EQUAL;

      // All fields of one refresh are taken on the same edge as the
      // toggle, so a master never sees a mixed sample.
      always @(posedge clk_i) begin
        if (rst_i) begin
          under_ff <= 1'b0;
          over_ff  <= 1'b0;
          lim1_ff  <= `RTDR_LIM_OFF;
          lim2_ff  <= `RTDR_LIM_OFF;
          err_ff   <= 1'b0;
          tog_ff   <= 1'b0;
          val_ff   <= `RTDR_VALUE_RST;                            // see R7
          sraw_ff  <= 32'h0000_0000;
          sres_ff  <= 16'h0000;
          lraw_ff  <= 32'h0000_0000;
          lres_ff  <= 16'h0000;
        end else if (smp_stb_i[g]) begin                          // see R14
          under_ff <= nxt_under;                                  // see R1
          over_ff  <= nxt_over;                                   // see R2
          lim1_ff  <= nxt_lim1;
          lim2_ff  <= nxt_lim2;
          err_ff   <= nxt_err;                                    // see R4
          tog_ff   <= ~tog_ff;                                    // see R6
          val_ff   <= sv;                                         // see R7
          sraw_ff  <= smp_sens_raw_i[g*32 +: 32];                 // see R10
          sres_ff  <= smp_sens_res_i[g*16 +: 16];                 // see R8
          lraw_ff  <= (HAS_LINE != 0) ? smp_line_raw_i[g*32 +: 32]
                                      : 32'h0000_0000;            // see R10
          lres_ff  <= (HAS_LINE != 0) ? smp_line_res_i[g*16 +: 16]
                                      : 16'h0000;                 // see R9
        end
      end

      // Calibration words; even entries are offsets, odd ones gains.
      // Byte lanes let software patch one half of a word without reading
      // it first; only a reset brings the factory values back.
      always @(posedge clk_i) begin
        if (rst_i) begin
          for (k = 0; k < `RTDR_CAL_ENTRIES; k = k + 1) begin
            cal_ff[k] <= k[0] ? `RTDR_CAL_GAIN_RST
                              : `RTDR_CAL_OFFS_RST;               // see R11
          end
        end else if (wr_now && ch_hit && (ch_sel == g)) begin
          for (k = 0; k < `RTDR_CAL_ENTRIES; k = k + 1) begin
            if (ch_word == `RTDR_W_CAL_FIRST + k[3:0]) begin      // see R12
              cal_ff[k] <= (cal_ff[k] & ~wmask16) |
                           (wb_dat_i[15:0] & wmask16);            // see R11
            end
          end
        end
      end

      // The flat output keeps entry e of channel g at bit 96g+16e.
      for (e = 0; e < `RTDR_CAL_ENTRIES; e = e + 1) begin : g_cal
        assign cal_o[g*96 + e*16 +: 16] = cal_ff[e];
      end

      // The invalid bit repeats the error flag: both say the sample is not
      // usable, one as process-data state and one as a channel flag.
      assign st_flat[g*`RTDR_ST_W +: `RTDR_ST_W] =            // see R5
        {tog_ff, err_ff, err_ff, lim2_ff, lim1_ff, over_ff, under_ff};
      assign val_flat[g*16 +: 16]  = val_ff;
      assign sraw_flat[g*32 +: 32] = sraw_ff;
      assign sres_flat[g*16 +: 16] = sres_ff;
      assign lraw_flat[g*32 +: 32] = lraw_ff;
      assign lres_flat[g*16 +: 16] = lres_ff;
      assign ev_fresh[g] = smp_stb_i[g];
      // An error event fires only on the way into error, so a channel
      // that stays broken does not keep re-arming the interrupt.
      assign ev_err[g]   = smp_stb_i[g] & nxt_err & ~err_ff;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read multiplexer; unmapped and reserved addresses read as zero.
  // --------------------------------------------------------------------
  // The mux is latched on the taking edge, so a slow decode costs no
  // extra wait state on the bus.
  always @* begin
    nxt_dat = 32'h0000_0000;
    if (ch_hit) begin
      case (ch_word)
        `RTDR_W_INPUT_MAXSUB: begin
          nxt_dat[7:0] = `RTDR_INPUT_MAXSUB;                      // see R13
        end
        `RTDR_W_STATUS: begin
          nxt_dat[`RTDR_ST_W-1:0] = st_flat[ch_sel*`RTDR_ST_W +: `RTDR_ST_W];
        end
        `RTDR_W_VALUE: begin
          nxt_dat[15:0] = val_flat[ch_sel*16 +: 16];              // see R7
        end
        `RTDR_W_INT_MAXSUB: begin
          nxt_dat[7:0] = `RTDR_INT_MAXSUB;
        end
        `RTDR_W_SENS_RAW: begin
          nxt_dat = sraw_flat[ch_sel*32 +: 32];                   // see R10
        end
        `RTDR_W_SENS_RES: begin
          nxt_dat[15:0] = sres_flat[ch_sel*16 +: 16];             // see R8
        end
        `RTDR_W_LINE_RAW: begin
          nxt_dat = lraw_flat[ch_sel*32 +: 32];                   // see R10
        end
        `RTDR_W_LINE_RES: begin
          nxt_dat[15:0] = lres_flat[ch_sel*16 +: 16];             // see R9
        end
        `RTDR_W_CAL_MAXSUB: begin
          nxt_dat[7:0] = `RTDR_CAL_MAXSUB;
        end
        default: begin
          // Calibration entries take words 9 to 14 of the window; word 15 reads zero.
          if ((ch_word >= `RTDR_W_CAL_FIRST) &&
              (ch_word < `RTDR_W_CAL_FIRST + `RTDR_CAL_ENTRIES)) begin
            nxt_dat[15:0] = cal_o[ch_sel*96 +
                                  (ch_word - `RTDR_W_CAL_FIRST)*16 +: 16];
          end
        end
      endcase
    end else begin
      // Global registers need the full address to match.
      case (wb_adr_i)
        `RTDR_ADR_IRQ_STAT:   nxt_dat[15:0] = irq_stat_ff;
        `RTDR_ADR_IRQ_MASK:   nxt_dat[15:0] = irq_mask_ff;
        `RTDR_ADR_RANGE_LO:   nxt_dat[15:0] = range_lo_ff;
        `RTDR_ADR_RANGE_HI:   nxt_dat[15:0] = range_hi_ff;
        `RTDR_ADR_LIMIT_ONE:  nxt_dat[15:0] = lim_one_ff;
        `RTDR_ADR_LIMIT_TWO:  nxt_dat[15:0] = lim_two_ff;
        `RTDR_ADR_LIMIT_EN:   nxt_dat[1:0]  = lim_en_ff;
        `RTDR_ADR_SFS_MAXSUB: nxt_dat[7:0]  = `RTDR_SFS_MAXSUB;
        `RTDR_ADR_SFM_MAXSUB: nxt_dat[7:0]  = `RTDR_SFM_MAXSUB;
        default:              nxt_dat       = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Ack, read data and configuration registers.
  // --------------------------------------------------------------------
  // Read data is latched with ack so it stays put while ack is high.
  // A request held through its ack cycle is not taken twice: ack blocks the
  // take in that cycle, so the next access may start in the cycle after ack.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff      <= 1'b0;
      dat_ff      <= 32'h0000_0000;
      irq_mask_ff <= 16'h0000;
      range_lo_ff <= `RTDR_RANGE_LO_RST;
      range_hi_ff <= `RTDR_RANGE_HI_RST;
      lim_one_ff  <= 16'h0000;
      lim_two_ff  <= 16'h0000;
      lim_en_ff   <= 2'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req && !ack_ff) begin
        dat_ff <= wb_we_i ? 32'h0000_0000 : nxt_dat;
      end
      // Writes to read-only or unmapped places fall to the default and
      // are dropped, though they are still acknowledged.
      if (wr_now && !ch_hit) begin
        case (wb_adr_i)
          `RTDR_ADR_IRQ_MASK: begin
            irq_mask_ff <= (irq_mask_ff & ~wmask16) |
                           (wb_dat_i[15:0] & wmask16);
          end
          `RTDR_ADR_RANGE_LO: begin
            range_lo_ff <= (range_lo_ff & ~wmask16) |
                           (wb_dat_i[15:0] & wmask16);
          end
          `RTDR_ADR_RANGE_HI: begin
            range_hi_ff <= (range_hi_ff & ~wmask16) |
                           (wb_dat_i[15:0] & wmask16);
          end
          `RTDR_ADR_LIMIT_ONE: begin
            lim_one_ff <= (lim_one_ff & ~wmask16) | (wb_dat_i[15:0] & wmask16);
          end
          `RTDR_ADR_LIMIT_TWO: begin
            lim_two_ff <= (lim_two_ff & ~wmask16) | (wb_dat_i[15:0] & wmask16);
          end
          `RTDR_ADR_LIMIT_EN: begin
            if (wb_sel_i[0]) begin
              lim_en_ff <= wb_dat_i[1:0];
            end
          end
          default: begin
            lim_en_ff <= lim_en_ff;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status: fresh samples in bits 7:0, new errors in 15:8.
  // --------------------------------------------------------------------
  // Write-one-to-clear; an event in the clearing cycle wins over the clear.
  // Fresh-sample bits fire on every refresh, so software that only wants
  // faults leaves bits 7:0 masked.
  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_now && !ch_hit && (wb_adr_i == `RTDR_ADR_IRQ_STAT)) begin
      nxt_irq_stat = irq_stat_ff & ~(wb_dat_i[15:0] & wmask16);
    end
    nxt_irq_stat[NCH-1:0]   = nxt_irq_stat[NCH-1:0] | ev_fresh;
    nxt_irq_stat[8 +: NCH]  = nxt_irq_stat[8 +: NCH] | ev_err;
  end

  // The status word has no other writer, so the rule above is the whole
  // of its behaviour.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 16'h0000;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // A plain AND/OR of flip-flops, so the line cannot glitch on a decode.
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

endmodule

// ==== verif/rtdr_properties.sv ====
`timescale 1ns/100ps
`include "rtdr_consts.vh"
// ----------------------------------------------------------------------
// Checker on the readout ports; channel 0 is shadowed locally.
// ----------------------------------------------------------------------
module rtdr_properties #(
  parameter NCH = 4
) (
  input wire              clk_i,
  input wire              rst_i,
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_we_i,
  input wire [11:0]       wb_adr_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  input wire [NCH-1:0]    smp_stb_i,
  input wire [NCH-1:0]    smp_ok_i,
  input wire [NCH*16-1:0] smp_value_i,
  input wire [NCH*96-1:0] cal_o,
  input wire              irq_o
);
  reg        tog_ff;
  reg        ok_ff;
  reg [15:0] val_ff;
  wire       rd_req;

  // Shadow of channel 0, so reads can be judged without the body.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tog_ff <= 1'b0;
      ok_ff  <= 1'b1;
      val_ff <= 16'h0000;
    end else if (smp_stb_i[0]) begin
      tog_ff <= ~tog_ff;
      ok_ff  <= smp_ok_i[0];
      val_ff <= smp_value_i[15:0];
    end
  end

  // A read request taken at this edge; its data is judged one cycle on.
  assign rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_reset_out;
    $fell(rst_i) |-> !wb_ack_o && !irq_o &&
      cal_o[31:0] == {`RTDR_CAL_GAIN_RST, `RTDR_CAL_OFFS_RST};
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("bad reset outputs");
  property p_maxsub;
    rd_req && wb_adr_i == 12'h200 |=> wb_dat_o == 32'h0000_0011;
  endproperty
  a_maxsub: assert property (p_maxsub)
    else $error("bad max subindex");
  property p_toggle;
    rd_req && wb_adr_i == 12'h204 |=> wb_dat_o[8] == $past(tog_ff);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("bad toggle");
  property p_err_inv;
    rd_req && wb_adr_i == 12'h204 |=>
      wb_dat_o[7] == wb_dat_o[6] && (wb_dat_o[6] || $past(ok_ff));
  endproperty
  a_err_inv: assert property (p_err_inv)
    else $error("bad error flag");
  property p_range_err;
    rd_req && wb_adr_i == 12'h204 |=> !(wb_dat_o[0] && wb_dat_o[1]) &&
      (!(wb_dat_o[0] || wb_dat_o[1]) || wb_dat_o[6]);
  endproperty
  a_range_err: assert property (p_range_err)
    else $error("bad range flags");
  property p_value;
    rd_req && wb_adr_i == 12'h208 |=>
      wb_dat_o == {16'h0000, $past(val_ff)};
  endproperty
  a_value: assert property (p_value)
    else $error("bad value");

  c_status: cover property (rd_req && wb_adr_i == 12'h204);
  c_irq: cover property (irq_o);
  c_bad: cover property (smp_stb_i[0] && !smp_ok_i[0]);
endmodule

bind rtdr_readout rtdr_properties #(.NCH(NCH)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_stb_i(smp_stb_i),
  .smp_ok_i(smp_ok_i), .smp_value_i(smp_value_i), .cal_o(cal_o),
  .irq_o(irq_o));

// ==== verif/rtdr_conv_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Converter model: one strobe per cycle while the request is high.
// ----------------------------------------------------------------------
module rtdr_conv_model #(
  parameter NCH = 4
) (
  input  wire              clk_i,
  input  wire              req_i,
  input  wire [2:0]        ch_i,
  input  wire              ok_i,
  input  wire [15:0]       val_i,
  input  wire [15:0]       res_i,
  output reg  [NCH-1:0]    stb_o = '0,
  output reg  [NCH-1:0]    ok_o = '0,
  output reg  [NCH*16-1:0] val_o = '0,
  output reg  [NCH*16-1:0] sres_o = '0,
  output reg  [NCH*16-1:0] lres_o = '0,
  output reg  [NCH*32-1:0] sraw_o = '0,
  output reg  [NCH*32-1:0] lraw_o = '0
);
  // Data is only good with the strobe; otherwise it flips every cycle,
  // so a block that samples off the strobe edge reads garbage.
  always @(posedge clk_i) begin
    stb_o  <= '0;
    ok_o   <= ~ok_o;
    val_o  <= ~val_o;
    sres_o <= ~sres_o;
    lres_o <= ~lres_o;
    sraw_o <= ~sraw_o;
    lraw_o <= ~lraw_o;
    if (req_i) begin
      stb_o[ch_i]           <= 1'b1;
      ok_o[ch_i]            <= ok_i;
      val_o[ch_i*16 +: 16]  <= val_i;
      sres_o[ch_i*16 +: 16] <= res_i;
      lres_o[ch_i*16 +: 16] <= ~res_i;
      sraw_o[ch_i*32 +: 32] <= {res_i, val_i};
      lraw_o[ch_i*32 +: 32] <= ~{res_i, val_i};
    end
  end
endmodule

// ==== verif/test_rtdr_readout.sv ====
`timescale 1ns/100ps
module test_rtdr_readout;
  localparam NCH = 4;
  reg              clk_i = 1'b0;
  reg              rst_i = 1'b1;
  reg              wb_cyc_i = 1'b0;
  reg              wb_stb_i = 1'b0;
  reg              wb_we_i = 1'b0;
  reg  [11:0]      wb_adr_i = 12'h000;
  reg  [3:0]       wb_sel_i = 4'h0;
  reg  [31:0]      wb_dat_i = 32'h0;
  wire [31:0]      wb_dat_o;
  wire             wb_ack_o;
  wire             irq_o;
  wire [NCH*96-1:0] cal_o;
  wire [NCH-1:0]   stb, okw;
  wire [NCH*16-1:0] valw, sres, lres;
  wire [NCH*32-1:0] sraw, lraw;
  reg              req = 1'b0;
  reg              ok = 1'b1;
  reg  [2:0]       ch = 3'h0;
  reg  [15:0]      val = 16'h0, res = 16'h0, v;
  reg  [31:0]      rd;
  reg  [NCH-1:0]   tog = '0;
  integer          n_fail = 0, samples_checked = 0, cycles = 0, i, c;
  // Rows: {data good, value, expected status byte}; limits 100 and -50.
  reg  [24:0] rows [0:8] = '{25'h100641c, 25'h1000018, 25'h1ffce38,
    25'h1ff0028, 25'h1f82fe9, 25'h12135d6, 25'h1213414, 25'h1f83028,
    25'h00010d8};

  always #25 clk_i = ~clk_i;

  rtdr_readout u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .smp_stb_i(stb), .smp_ok_i(okw),
    .smp_value_i(valw), .smp_sens_raw_i(sraw), .smp_sens_res_i(sres),
    .smp_line_raw_i(lraw), .smp_line_res_i(lres), .cal_o(cal_o),
    .irq_o(irq_o));
  rtdr_conv_model u_conv (.clk_i(clk_i), .req_i(req), .ch_i(ch),
    .ok_i(ok), .val_i(val), .res_i(res), .stb_o(stb), .ok_o(okw),
    .val_o(valw), .sres_o(sres), .lres_o(lres), .sraw_o(sraw),
    .lraw_o(lraw));

  task wrap_up;
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is seen at a rising edge.
  task wb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rdc(input [11:0] a, input [31:0] exp);
    wb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  // Issue cnt back-to-back strobes, then let the last one land.
  task smp(input [2:0] k, input o, input [15:0] x, input [15:0] r,
           input integer cnt);
    integer j;
    for (j = 0; j < cnt; j++) begin
      @(posedge clk_i);
      req <= 1'b1;
      ch  <= k;
      ok  <= o;
      val <= x + j;
      res <= r + j;
    end
    @(posedge clk_i);
    req <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // A hang is cut short here and counted.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      wrap_up;
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'h200, 32'h11);
    rdc(12'h204, 32'h0);
    rdc(12'h208, 32'h0);
    rdc(12'h20c, 32'h04);
    for (i = 0; i < 6; i++) rdc(12'h224 + 4 * i, i % 2 ? 32'h9e50 : 0);
    chk(cal_o[31:0], 32'h9e50_0000);
    wb(1'b1, 12'h010, 32'h0064, 4'h3);
    wb(1'b1, 12'h014, 32'hffce, 4'h3);
    wb(1'b1, 12'h018, 32'h3, 4'h1);
    for (i = 0; i < 9; i++) begin
      c = i % 4;
      v = rows[i][23:8];
      smp(c, rows[i][24], v, v ^ 16'h5a5a, 1);
      tog[c] = ~tog[c];
      rdc(12'h204 + 64 * c, {23'h0, tog[c], rows[i][7:0]});
      rdc(12'h208 + 64 * c, {16'h0, v});
      rdc(12'h214 + 64 * c, {16'h0, v ^ 16'h5a5a});
      rdc(12'h21c + 64 * c, {16'h0, ~(v ^ 16'h5a5a)});
      rdc(12'h218 + 64 * c, ~{v ^ 16'h5a5a, v});
    end
    // Read-only places ignore writes; unmapped space reads zero.
    wb(1'b1, 12'h210, 32'h0, 4'hf);
    rdc(12'h210, 32'h5a4a_0010);
    wb(1'b1, 12'h200, 32'h0, 4'hf);
    rdc(12'h200, 32'h11);
    rdc(12'h800, 32'h0);
    wb(1'b1, 12'h018, 32'h0, 4'h1);
    smp(1, 1'b1, 16'h0064, 16'h0, 1);
    tog[1] = ~tog[1];
    rdc(12'h244, {23'h0, tog[1], 8'h00});
    smp(2, 1'b1, 16'h0100, 16'h0, 2);
    rdc(12'h288, 32'h0101);
    rdc(12'h284, {23'h0, tog[2], 8'h00});
    wb(1'b1, 12'h224, 32'hffff_1234, 4'h3);
    wb(1'b1, 12'h224, 32'h0000_abcd, 4'h1);
    rdc(12'h224, 32'h12cd);
    chk({16'h0, cal_o[15:0]}, 32'h12cd);
    // Sticky events, masked at first, then one routed to the output.
    rdc(12'h000, 32'h030f);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, 12'h000, 32'hffff, 4'h3);
    rdc(12'h000, 32'h0);
    wb(1'b1, 12'h004, 32'h1, 4'h1);
    smp(0, 1'b1, 16'h0, 16'h0, 1);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, 12'h000, 32'h1, 4'h1);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // A reset in mid-run brings channel, calibration and status back.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'h204, 32'h0);
    rdc(12'h208, 32'h0);
    rdc(12'h224, 32'h0);
    rdc(12'h228, 32'h9e50);
    rdc(12'h000, 32'h0);
    rdc(12'h01c, 32'h06);
    rdc(12'h020, 32'h03);
    chk({16'h0, cal_o[15:0]}, 32'h0);
    wrap_up;
  end
endmodule
